//--- src/nhbi_pkg.sv
// Package with constants and types shared by the host bus interface files
package nhbi_pkg;

  // Register file geometry
  localparam int unsigned REG_COUNT      = 16;
  localparam int unsigned REG_SEL_WIDTH  = 4;
  localparam int unsigned REG_DATA_WIDTH = 8;
  localparam int unsigned BUS_WIDTH      = 16;

  // Register indices reached through the register select lines
  localparam logic [3:0] REG_REMOTE_START_ADDR_LOW  = 4'h8;
  localparam logic [3:0] REG_REMOTE_START_ADDR_HIGH = 4'h9;
  localparam logic [3:0] REG_DATA_CONFIG            = 4'hE;

  // Field position of the long-address select bit in the data configuration register
  localparam int unsigned DCR_LONG_ADDRESS_SELECT_BIT = 2;

  // Reset value of every register in the file
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // Default bus clock divider: fast clock cycles per bus clock phase
  localparam int unsigned BUS_CLOCK_DIV_DEFAULT = 4;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  // DMA memory cycle phases, one-hot
  typedef enum logic [6:0] {
    NHBI_IDLE  = 7'h01,  // Bus not owned or no work pending
    NHBI_UPPER = 7'h02,  // Upper address strobe phase (long-address mode)
    NHBI_T1    = 7'h04,  // Address phase
    NHBI_T2    = 7'h08,  // First strobe phase
    NHBI_T3    = 7'h10,  // Ready sampled here
    NHBI_TW    = 7'h20,  // Wait state
    NHBI_T4    = 7'h40   // Data captured, cycle ends
  } nhbi_state_t;

  // Pin inputs after synchronisation
  typedef struct packed {
    logic        chipSelectN;       // Host chip select, active low
    logic        hostWriteStrobeN;  // Host write strobe, active low
    logic        hostReadStrobeN;   // Host read strobe, active low
    logic [3:0]  registerSelect;    // Register index
    logic        busGrant;          // Bus grant, active high
    logic        ready;             // High requests a wait state
    logic        portReadDone;      // Latch was read by the host
    logic [15:0] muxAddrData;       // Shared address/data bus level
  } nhbi_pins_t;

  localparam int unsigned PINS_WIDTH = $bits(nhbi_pins_t);

endpackage : nhbi_pkg

//--- src/nhbi_pin_sync.sv
// Three-stage synchroniser with agreement filter for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none

module nhbi_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,       // System clock
  input  wire logic             reset,     // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] pinIn,     // Raw asynchronous levels
  output logic      [WIDTH-1:0] pinStable  // Filtered, synchronous levels
);

  initial begin
    if (WIDTH < 1) $error("nhbi_pin_sync: WIDTH must be at least 1");
  end

  // One chain per bit; a change is taken only once stages two and three agree
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic stage1;  // Metastable stage, read only by stage2
      logic stage2;  // Second stage
      logic stage3;  // Third stage
      logic nextStable;

      // Next filtered value
      always_comb begin
        nextStable = (stage2 == stage3) ? stage3 : pinStable[b];
      end

      // Register the chain
      always_ff @(posedge clk) begin
        if (reset) begin
          stage1       <= 1'b0;
          stage2       <= 1'b0;
          stage3       <= 1'b0;
          pinStable[b] <= 1'b0;
        end else begin
          stage1       <= pinIn[b];
          stage2       <= stage1;
          stage3       <= stage2;
          pinStable[b] <= nextStable;
        end
      end
    end
  endgenerate

endmodule : nhbi_pin_sync

`default_nettype wire

//--- src/nhbi_host_bus.sv
// Host bus interface: register slave port, DMA memory cycles and remote port
`timescale 1ns/1ps
`default_nettype none

module nhbi_host_bus #(
  parameter int unsigned BUS_CLOCK_DIV = nhbi_pkg::BUS_CLOCK_DIV_DEFAULT  // Clocks per bus phase
) (
  input  wire logic        clk,                // System clock, 250 MHz
  input  wire logic        reset,              // Synchronous reset, active high
  // Host slave pins
  input  wire logic        chipSelectN,        // Chip select, active low
  input  wire logic        hostWriteStrobeN,   // Host write strobe, active low
  input  wire logic        hostReadStrobeN,    // Host read strobe, active low
  input  wire logic [3:0]  registerSelect,     // Register index
  output logic             accessGrantN,       // Access grant, active low
  // Shared address/data bus, three signals
  input  wire logic [15:0] muxAddrDataIn,      // Bus level seen at the pins
  output logic      [15:0] muxAddrDataOut,     // Value driven by the block
  output logic             muxAddrDataOeN,     // Low while the block drives
  // DMA master pins
  output logic             busRequestOut,      // Bus request, active high
  input  wire logic        busGrant,           // Bus grant, active high
  input  wire logic        ready,              // High inserts wait states
  output logic             dmaReadStrobeN,     // DMA read strobe, active low
  output logic             dmaReadStrobeOeN,   // Low while the strobe is driven
  // Remote port pins
  input  wire logic        portReadDone,       // Host has read the latch
  output logic             portLatchStrobeN,   // Latch strobe, rising edge latches
  output logic             dualPinOut,         // Port request or upper address strobe
  output logic             dualPinOeN,         // Low while the dual pin is driven
  // Internal side
  input  wire logic        fifoNeedsService,   // FIFO wants a memory read
  input  wire logic [15:0] fifoAddress,        // Buffer address for FIFO reads
  input  wire logic [15:0] remoteAddress,      // Buffer address for remote reads
  output logic      [15:0] dmaReadData,        // Data captured from buffer memory
  output logic             dmaReadValid,       // One-cycle pulse with new data
  output logic             dmaReadRemote       // Captured cycle was a remote read
);

  initial begin
    if (BUS_CLOCK_DIV < 2) $error("nhbi_host_bus: BUS_CLOCK_DIV must be at least 2");
  end

  // Synchronised pin bundle
  nhbi_pkg::nhbi_pins_t pins;
  logic [nhbi_pkg::PINS_WIDTH-1:0] pinsStable;

  nhbi_pin_sync #(.WIDTH(nhbi_pkg::PINS_WIDTH)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .pinIn    ({~chipSelectN, ~hostWriteStrobeN, ~hostReadStrobeN, registerSelect,
                busGrant, ready, portReadDone, muxAddrDataIn}),
    .pinStable(pinsStable)
  );

  // Active-low strobes pass the chain inverted, so the chain's reset value of zero
  // reads as their idle high level and no false access follows reset
  always_comb begin
    pins                  = nhbi_pkg::nhbi_pins_t'(pinsStable);
    pins.chipSelectN      = !pins.chipSelectN;
    pins.hostWriteStrobeN = !pins.hostWriteStrobeN;
    pins.hostReadStrobeN  = !pins.hostReadStrobeN;
  end

  // ---------------- Bus phase divider ----------------
  logic [7:0] divCount;       // Counts fast cycles within a bus phase
  logic [7:0] next_divCount;
  logic       busTick;        // One-cycle enable marking a bus phase boundary

  // Next divider value
  always_comb begin
    busTick       = (divCount == 8'(BUS_CLOCK_DIV - 1));
    next_divCount = busTick ? 8'h00 : divCount + 8'h01;
  end

  // Register divider
  always_ff @(posedge clk) begin
    if (reset) divCount <= 8'h00;
    else       divCount <= next_divCount;
  end

  // ---------------- Host register file ----------------
  logic [7:0] regFile [nhbi_pkg::REG_COUNT];  // Registers the host reaches
  logic [7:0] next_regFile [nhbi_pkg::REG_COUNT];
  logic       prevWriteN;      // Last synced write strobe, for edge detect
  logic       prevReadDone;    // Last synced read-done, for edge detect
  logic       configWritten;   // Data configuration register has been written
  logic       next_configWritten;
  logic       writeEdge;       // Rising edge of a selected host write
  logic       hostRead;        // Selected host read in progress
  logic       hostActive;      // Any selected host access in progress
  logic       longAddr;        // Long-address select bit

  // Next register contents; writes land on the strobe's rising edge
  always_comb begin
    next_regFile       = regFile;
    next_configWritten = configWritten;
    writeEdge          = pins.hostWriteStrobeN && !prevWriteN && !pins.chipSelectN;
    if (writeEdge) begin
      next_regFile[pins.registerSelect] = pins.muxAddrData[7:0];
      if (pins.registerSelect == nhbi_pkg::REG_DATA_CONFIG) next_configWritten = 1'b1;
    end
  end

  // Register the file and edge trackers
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < nhbi_pkg::REG_COUNT; i++) regFile[i] <= nhbi_pkg::REG_RESET_VALUE;
      configWritten <= 1'b0;
      prevWriteN    <= 1'b1;
      prevReadDone  <= 1'b0;
    end else begin
      regFile       <= next_regFile;
      configWritten <= next_configWritten;
      prevWriteN    <= pins.hostWriteStrobeN;
      prevReadDone  <= pins.portReadDone;
    end
  end

  assign longAddr = regFile[nhbi_pkg::REG_DATA_CONFIG][nhbi_pkg::DCR_LONG_ADDRESS_SELECT_BIT];

  // ---------------- DMA cycle sequencer ----------------
  nhbi_pkg::nhbi_state_t state, next_state;
  logic remotePending, next_remotePending;  // Latch refill owed
  logic cycleRemote, next_cycleRemote;      // Current cycle refills the latch
  logic [15:0] next_dmaReadData;
  logic next_dmaReadValid;
  logic next_dmaReadRemote;
  logic readDoneEdge;                       // Synced rising edge of read-done
  logic workPending;                        // Any memory read owed

  // Next sequencer state; phases move only on bus ticks
  always_comb begin
    next_state         = state;
    next_cycleRemote   = cycleRemote;
    next_dmaReadData   = dmaReadData;
    next_dmaReadValid  = 1'b0;
    next_dmaReadRemote = dmaReadRemote;
    readDoneEdge       = pins.portReadDone && !prevReadDone;
    workPending        = remotePending || fifoNeedsService;
    next_remotePending = remotePending;
    // Finishing a remote cycle clears the debt; a new edge in that cycle still wins
    if (state == nhbi_pkg::NHBI_T4 && busTick && cycleRemote) next_remotePending = 1'b0;
    if (readDoneEdge) next_remotePending = 1'b1;
    if (busTick) begin
      unique case (state)
        nhbi_pkg::NHBI_IDLE: begin
          // Only start once the owner has granted the bus
          if (workPending && pins.busGrant) begin
            next_cycleRemote = remotePending;  // Remote refill takes priority
            next_state = longAddr ? nhbi_pkg::NHBI_UPPER : nhbi_pkg::NHBI_T1;
          end
        end
        nhbi_pkg::NHBI_UPPER: next_state = nhbi_pkg::NHBI_T1;
        nhbi_pkg::NHBI_T1:    next_state = nhbi_pkg::NHBI_T2;
        nhbi_pkg::NHBI_T2:    next_state = nhbi_pkg::NHBI_T3;
        nhbi_pkg::NHBI_T3,
        nhbi_pkg::NHBI_TW: begin
          // Ready high buys exactly one more phase each time it is seen
          next_state = pins.ready ? nhbi_pkg::NHBI_TW : nhbi_pkg::NHBI_T4;
          if (!pins.ready) begin
            // Strobe rises at this boundary: take the data now
            next_dmaReadData   = pins.muxAddrData;
            next_dmaReadValid  = 1'b1;
            next_dmaReadRemote = cycleRemote;
          end
        end
        nhbi_pkg::NHBI_T4:    next_state = nhbi_pkg::NHBI_IDLE;
      endcase
    end
  end

  // Register sequencer state
  always_ff @(posedge clk) begin
    if (reset) begin
      state         <= nhbi_pkg::NHBI_IDLE;
      remotePending <= 1'b0;
      cycleRemote   <= 1'b0;
      dmaReadData   <= 16'h0000;
      dmaReadValid  <= 1'b0;
      dmaReadRemote <= 1'b0;
    end else begin
      state         <= next_state;
      remotePending <= next_remotePending;
      cycleRemote   <= next_cycleRemote;
      dmaReadData   <= next_dmaReadData;
      dmaReadValid  <= next_dmaReadValid;
      dmaReadRemote <= next_dmaReadRemote;
    end
  end

  // ---------------- Pin outputs ----------------
  logic next_accessGrantN;
  logic [15:0] next_muxOut;
  logic next_muxOeN, next_strobeN, next_strobeOeN, next_latchN, next_dualOut, next_dualOeN;

  // Next pin values; all pins leave flip-flops
  always_comb begin
    // Access grant and register reads only while the sequencer is in IDLE; writes land in any state
    hostActive = !pins.chipSelectN && (state == nhbi_pkg::NHBI_IDLE) &&
                 (!pins.hostReadStrobeN || !pins.hostWriteStrobeN);
    hostRead   = hostActive && !pins.hostReadStrobeN;
    next_accessGrantN = !hostActive;
    next_muxOut = 16'h0000;
    next_muxOeN = 1'b1;
    if (hostRead) begin
      next_muxOut = {8'h00, regFile[pins.registerSelect]};
      next_muxOeN = 1'b0;
    end else if (state == nhbi_pkg::NHBI_UPPER) begin
      next_muxOut = {regFile[nhbi_pkg::REG_REMOTE_START_ADDR_HIGH],
                     regFile[nhbi_pkg::REG_REMOTE_START_ADDR_LOW]};
      next_muxOeN = 1'b0;
    end else if (state == nhbi_pkg::NHBI_T1) begin
      next_muxOut = cycleRemote ? remoteAddress : fifoAddress;
      next_muxOeN = 1'b0;
    end else if (state == nhbi_pkg::NHBI_T4 && cycleRemote) begin
      next_muxOut = dmaReadData;  // Held for the latch until the strobe rises
      next_muxOeN = 1'b0;
    end
    // Strobe is low in T2, T3 and waits; it floats without grant
    next_strobeN   = !(state inside {nhbi_pkg::NHBI_T2, nhbi_pkg::NHBI_T3,
                                     nhbi_pkg::NHBI_TW});
    next_strobeOeN = !pins.busGrant;
    next_latchN    = !(state == nhbi_pkg::NHBI_T4 && cycleRemote);
    // Dual pin: floats until configured, then port request or upper strobe
    if (!configWritten) begin
      next_dualOut = 1'b0;
      next_dualOeN = 1'b1;
    end else if (longAddr) begin
      next_dualOut = (state == nhbi_pkg::NHBI_UPPER);
      next_dualOeN = !pins.busGrant;
    end else begin
      next_dualOut = remotePending;
      next_dualOeN = 1'b0;
    end
  end

  // Register pin outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      accessGrantN     <= 1'b1;
      muxAddrDataOut   <= 16'h0000;
      muxAddrDataOeN   <= 1'b1;
      dmaReadStrobeN   <= 1'b1;
      dmaReadStrobeOeN <= 1'b1;
      portLatchStrobeN <= 1'b1;
      dualPinOut       <= 1'b0;
      dualPinOeN       <= 1'b1;
      busRequestOut    <= 1'b0;
    end else begin
      accessGrantN     <= next_accessGrantN;
      muxAddrDataOut   <= next_muxOut;
      muxAddrDataOeN   <= next_muxOeN;
      dmaReadStrobeN   <= next_strobeN;
      dmaReadStrobeOeN <= next_strobeOeN;
      portLatchStrobeN <= next_latchN;
      dualPinOut       <= next_dualOut;
      dualPinOeN       <= next_dualOeN;
      // Request held until the cycle is over, so the grant cannot vanish mid-cycle
      busRequestOut    <= workPending || (state != nhbi_pkg::NHBI_IDLE);
    end
  end

  // ---------------- Checks ----------------
  logic [7:0] phaseCount;  // Bus phases spent in T1..TW of the current cycle
  logic [7:0] waitCount;   // Wait phases in the current cycle
  always_ff @(posedge clk) begin
    if (reset || state == nhbi_pkg::NHBI_IDLE) begin
      phaseCount <= 8'h00;
      waitCount  <= 8'h00;
    end else if (busTick && state != nhbi_pkg::NHBI_UPPER) begin
      phaseCount <= phaseCount + 8'h01;
      if (state == nhbi_pkg::NHBI_TW) waitCount <= waitCount + 8'h01;
    end
  end

  read_strobe_a: assert property (@(posedge clk) disable iff (reset)
    !dmaReadStrobeN |-> $past(state) inside {nhbi_pkg::NHBI_T2, nhbi_pkg::NHBI_T3,
                                            nhbi_pkg::NHBI_TW})
    else $error("read strobe low outside T2/T3/TW");
  strobe_float_a: assert property (@(posedge clk) disable iff (reset)
    !pins.busGrant |=> dmaReadStrobeOeN)
    else $error("read strobe driven without grant");
  host_write_a: assert property (@(posedge clk) disable iff (reset)
    writeEdge |=> regFile[$past(pins.registerSelect)] == $past(pins.muxAddrData[7:0]))
    else $error("host write not stored");
  host_read_a: assert property (@(posedge clk) disable iff (reset)
    hostRead |=> !muxAddrDataOeN && muxAddrDataOut[7:0] == $past(regFile[pins.registerSelect]))
    else $error("host read data wrong");
  access_grant_a: assert property (@(posedge clk) disable iff (reset)
    !accessGrantN |-> $past(hostActive) && $past(state) == nhbi_pkg::NHBI_IDLE)
    else $error("access granted before synchronisation");
  cycle_length_a: assert property (@(posedge clk) disable iff (reset)
    state == nhbi_pkg::NHBI_T4 && busTick |-> phaseCount == 8'h03 + waitCount)
    else $error("DMA cycle length wrong");
  ready_wait_a: assert property (@(posedge clk) disable iff (reset)
    state == nhbi_pkg::NHBI_T3 && busTick && pins.ready |=> state == nhbi_pkg::NHBI_TW)
    else $error("ready high did not insert a wait");
  latch_strobe_a: assert property (@(posedge clk) disable iff (reset)
    !portLatchStrobeN |-> !muxAddrDataOeN && muxAddrDataOut == dmaReadData)
    else $error("latch strobe without valid data");
  dual_float_a: assert property (@(posedge clk) disable iff (reset)
    !configWritten |=> dualPinOeN)
    else $error("dual pin driven before configuration");
  bus_drive_a: assert property (@(posedge clk) disable iff (reset)
    !muxAddrDataOeN |-> $past(hostRead) || $past(state) != nhbi_pkg::NHBI_IDLE)
    else $error("bus driven with no read or cycle");

endmodule : nhbi_host_bus

`default_nettype wire

//--- tb/nhbi_mem_model.sv
// Partner model: bus owner, buffer memory and shared bus level resolution
`timescale 1ns/1ps
`default_nettype none

module nhbi_mem_model (
  input  wire logic        clk,        // System clock
  input  wire logic        busRequest, // Request from the block
  input  wire logic        slow,       // High asks for wait states
  input  wire logic        strobeN,    // Read strobe from the block
  input  wire logic        strobeOeN,  // Strobe driven when low
  input  wire logic [15:0] dutOut,     // Block drive value
  input  wire logic        dutOeN,     // Block drives when low
  input  wire logic        hostOe,     // Host drives when high
  input  wire logic [15:0] hostOut,    // Host drive value
  output logic             busGrant,   // Grant to the block
  output logic             ready,      // High asks a wait
  output logic      [15:0] busLevel    // Resolved bus level
);
  logic [15:0] memAddr   = 16'h0000; // Address latched during T1
  logic [15:0] lastLevel = 16'h0000; // Floating bus shows its inverse
  logic [4:0]  lowCnt    = 5'h00;    // Clocks with strobe low

  // Grant follows the request one clock later, and is released one clock after it
  always @(posedge clk) begin
    busGrant <= busRequest;
  end

  // Latch address, remember level, count strobe-low clocks
  always @(posedge clk) begin
    if (!dutOeN && strobeN) memAddr <= dutOut;
    lastLevel <= busLevel;
    lowCnt <= (!strobeN && !strobeOeN) ? lowCnt + 5'h01 : 5'h00;
  end

  // Slow memory holds ready high for the first ten strobe clocks
  assign ready = slow && (lowCnt < 5'h0A);

  // Memory drives only under the strobe; a released bus never holds its value
  assign busLevel = !dutOeN ? dutOut : hostOe ? hostOut :
                    (!strobeN && !strobeOeN) ? (memAddr ^ 16'h5A3C) : ~lastLevel;

endmodule : nhbi_mem_model

`default_nettype wire

//--- tb/tb_nic_host_bus_interface.sv
// Self-checking testbench for the host bus interface
`timescale 1ns/1ps
`default_nettype none

module tb_nic_host_bus_interface;
  localparam int DIV = 4; // Clocks per bus phase
  logic        clk, reset, csN, wrN, rdN, grantN, busOeN, busReq, busGrant;
  logic        ready, strobeN, strobeOeN, portDone, latchN, dualOut, dualOeN;
  logic        fifoReq, rdValid, rdRemote, slow, hostOe, longMode;
  logic        prevOeN, prevLatch, latchDriven;
  logic [3:0]  regSel;
  logic [15:0] busIn, busOut, fifoAddr, remAddr, rdData, hostOut;
  logic [15:0] addrSeen, upperSeen, latchData, prevOut;
  int          n_fail = 0, check_count = 0, lowLen = 0, lastLow = 0;

  nhbi_host_bus #(.BUS_CLOCK_DIV(DIV)) dut (.clk(clk), .reset(reset),
    .chipSelectN(csN), .hostWriteStrobeN(wrN), .hostReadStrobeN(rdN),
    .registerSelect(regSel), .accessGrantN(grantN), .muxAddrDataIn(busIn),
    .muxAddrDataOut(busOut), .muxAddrDataOeN(busOeN), .busRequestOut(busReq),
    .busGrant(busGrant), .ready(ready), .dmaReadStrobeN(strobeN),
    .dmaReadStrobeOeN(strobeOeN), .portReadDone(portDone),
    .portLatchStrobeN(latchN), .dualPinOut(dualOut), .dualPinOeN(dualOeN),
    .fifoNeedsService(fifoReq), .fifoAddress(fifoAddr), .remoteAddress(remAddr),
    .dmaReadData(rdData), .dmaReadValid(rdValid), .dmaReadRemote(rdRemote));

  nhbi_mem_model mem (.clk(clk), .busRequest(busReq), .slow(slow),
    .strobeN(strobeN), .strobeOeN(strobeOeN), .dutOut(busOut), .dutOeN(busOeN),
    .hostOe(hostOe), .hostOut(hostOut), .busGrant(busGrant), .ready(ready),
    .busLevel(busIn));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Bus monitor: strobe length, T1 address, upper address, latched data
  always @(posedge clk) begin
    if (strobeN === 1'b0) lowLen++;
    else if (lowLen != 0) begin
      lastLow = lowLen;
      lowLen = 0;
    end
    if (!busOeN && grantN && latchN) begin
      if (longMode && dualOut) upperSeen = busOut;
      else if (strobeN) addrSeen = busOut;
    end
    // Latched value is what stood on the bus just before the rise
    if (prevLatch === 1'b0 && latchN === 1'b1) begin
      latchData = prevOut;
      latchDriven = !prevOeN;
    end
    prevLatch = latchN;
    prevOut = busOut;
    prevOeN = busOeN;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits n edges, then moves just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Host write; strobes held long enough to pass the pin filter
  task automatic hostWrite(input logic [3:0] sel, input logic [7:0] val);
    csN = 1'b0; regSel = sel; hostOe = 1'b1; hostOut = {8'h00, val}; step(6);
    wrN = 1'b0; step(6);
    wrN = 1'b1; step(6);
    csN = 1'b1; hostOe = 1'b0; step(4);
  endtask : hostWrite

  task automatic hostRead(input logic [3:0] sel, input logic [7:0] exp);
    int k;
    csN = 1'b0; regSel = sel; rdN = 1'b0; k = 0;
    while (grantN !== 1'b0 && k < 40) begin step(1); k++; end
    check(grantN, 16'h0000);
    check(busOut, {8'h00, exp});
    check(busOeN, 16'h0000);
    rdN = 1'b1; step(8);
    check(busOeN, 16'h0001);
    csN = 1'b1; step(4);
  endtask : hostRead

  task automatic waitValid;
    int k;
    k = 0;
    while (rdValid !== 1'b1 && k < 300) begin step(1); k++; end
    check(rdValid, 16'h0001);
  endtask : waitValid

  // Idle state after reset: every driver released
  task automatic t_reset;
    check(dualOeN, 16'h0001);
    check(strobeOeN, 16'h0001);
    check(busOeN, 16'h0001);
    check(busReq, 16'h0000);
    check(grantN, 16'h0001);
  endtask : t_reset

  // Address registers written and read back; dual pin still floats
  task automatic t_regs;
    hostWrite(4'h8, 8'h34);
    hostWrite(4'h9, 8'h12);
    hostRead(4'h8, 8'h34);
    hostRead(4'h9, 8'h12);
    check(dualOeN, 16'h0001);
  endtask : t_regs

  // Short mode: configuration written, pin becomes a driven request
  task automatic t_short;
    hostWrite(4'hE, 8'h00);
    step(2);
    check(dualOeN, 16'h0000);
    check(dualOut, 16'h0000);
  endtask : t_short

  // FIFO read, prompt or with wait states from slow memory
  task automatic t_fifo(input logic s);
    int k;
    fifoAddr = s ? 16'h0C40 : 16'h03F1; slow = s; fifoReq = 1'b1; k = 0;
    while (strobeN !== 1'b0 && k < 60) begin step(1); k++; end
    check(busReq, 16'h0001);
    fifoReq = 1'b0;
    waitValid();
    check(rdData, fifoAddr ^ 16'h5A3C);
    check(rdRemote, 16'h0000);
    check(addrSeen, fifoAddr);
    step(DIV + 2);
    if (!s) check(lastLow[15:0], 16'(2 * DIV));
    else begin
      check(16'(lastLow % DIV), 16'h0000);
      check(16'(lastLow > 2 * DIV), 16'h0001);
    end
    slow = 1'b0; step(10);
    check(strobeOeN, 16'h0001);
  endtask : t_fifo

  // Remote read started by the port read-done pulse
  task automatic t_remote(input logic lng);
    int k;
    remAddr = 16'h0420; portDone = 1'b1; step(4);
    portDone = 1'b0; k = 0;
    if (!lng) begin
      while (dualOut !== 1'b1 && k < 20) begin step(1); k++; end
      check(dualOut, 16'h0001);
    end
    waitValid();
    check(rdData, remAddr ^ 16'h5A3C);
    check(rdRemote, 16'h0001);
    step(DIV + 4);
    check(latchData, remAddr ^ 16'h5A3C);
    check(latchDriven, 16'h0001);
    if (lng) check(upperSeen, 16'h1234);
    else check(dualOut, 16'h0000);
    step(10);
  endtask : t_remote

  // Long mode: pin floats without grant, then strobes the upper address
  task automatic t_long;
    hostWrite(4'hE, 8'h04);
    longMode = 1'b1; step(2);
    check(dualOeN, 16'h0001);
    t_remote(1'b1);
  endtask : t_long

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    reset = 1'b1; csN = 1'b1; wrN = 1'b1; rdN = 1'b1; regSel = 4'h0;
    portDone = 1'b0; fifoReq = 1'b0; fifoAddr = 16'h0000; remAddr = 16'h0000;
    slow = 1'b0; hostOe = 1'b0; hostOut = 16'h0000; longMode = 1'b0;
    step(5);
    reset = 1'b0; step(5);
    t_reset();
    t_regs();
    t_short();
    t_fifo(1'b0);
    t_fifo(1'b1);
    t_remote(1'b0);
    t_long();
    summarize();
  end

  // Watchdog: 20000 clocks, far beyond the expected run of a few hundred clocks
  initial begin
    #80000;
    n_fail++;
    summarize();
  end

endmodule : tb_nic_host_bus_interface

`default_nettype wire
